// File: common/parport_pkg.sv
package parport_pkg;

    // ------------------------------------------------------------
    // Operating modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_OFF,
        MODE_COMPAT,
        MODE_NIBBLE,
        MODE_BYTE,
        MODE_ECP_FWD,
        MODE_ECP_REV
    } port_mode_type;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int FLAG_WIDTH   = 16;
    localparam int LINE_COUNT   = 4;
    localparam int DMA_CHANNELS = 2;
    localparam int TALLY_WIDTH  = 2;
    localparam int QUEUE_WIDTH  = 2;
    localparam int QUEUE_DEPTH  = 8;

    // ------------------------------------------------------------
    // Host line indexes into the line vector
    // ------------------------------------------------------------
    localparam int LINE_STROBE   = 0;
    localparam int LINE_AUTOFEED = 1;
    localparam int LINE_SELECTIN = 2;
    localparam int LINE_INIT     = 3;

    // ------------------------------------------------------------
    // Flag, condition and mask bit positions
    // Edge bit 2*i is the rising edge of line i, 2*i+1 the falling
    // ------------------------------------------------------------
    localparam int BIT_REINIT   = 13;
    localparam int BIT_COMMAND  = 14;
    localparam int BIT_DATA     = 15;

    // ------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------
    localparam logic [15:0] MASK_RESET  = 16'h0000;
    localparam logic [15:0] FLAG_RESET  = 16'h0000;
    localparam logic [15:0] FLAG_USED   = 16'h60FF;
    localparam logic [1:0]  TALLY_LAST  = 2'h3;
    localparam logic [1:0]  TALLY_RESET = 2'h0;

endpackage : parport_pkg

// File: hdl/access_queue.sv
`timescale 1ns/10ps
module access_queue #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wrPtr;
        logic [AW-1:0]               rdPtr;
        logic [AW:0]                 count;
    } queue_type;

    queue_type s;
    queue_type next_s;
    logic      push;
    logic      pop;

    assign inReady  = (s.count != (AW+1)'(DEPTH));
    assign outValid = (s.count != '0);
    assign outData  = s.mem[s.rdPtr];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wrPtr] = inData;
            next_s.wrPtr        = s.wrPtr + 1'b1;
        end
        if (pop) begin
            next_s.rdPtr = s.rdPtr + 1'b1;
        end
        if (push && !pop) begin
            next_s.count = s.count + 1'b1;
        end else if (pop && !push) begin
            next_s.count = s.count - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    count_range_a: assert property (@(posedge clk) disable iff (!resetn)
        s.count <= (AW+1)'(DEPTH)) else $error("queue count above depth");

endmodule : access_queue

// File: hdl/parallel_port_request_logic.sv
`timescale 1ns/10ps
module parallel_port_request_logic (
    input  wire logic                                 clk,
    input  wire logic                                 resetn,
    input  wire parport_pkg::port_mode_type           portMode,
    input  wire logic [parport_pkg::LINE_COUNT-1:0]   hostLines,
    input  wire logic                                 hostReinitReq,
    input  wire logic                                 reverseReady,
    input  wire logic                                 maskWrite,
    input  wire logic [parport_pkg::FLAG_WIDTH-1:0]   maskValue,
    input  wire logic                                 statusClear,
    input  wire logic [parport_pkg::FLAG_WIDTH-1:0]   clearBits,
    input  wire logic                                 dmaSelectBit,
    input  wire logic                                 dmaChannelSelect,
    input  wire logic                                 fullWordEnable,
    input  wire logic                                 expectedCommandPolarity,
    input  wire logic                                 cpuRead,
    input  wire logic                                 cpuWrite,
    output logic                                      cpuReady,
    input  wire logic                                 dmaAck,
    output logic                                      dmaReady,
    output logic                                      accessReq,
    output logic                                      accessIsDma,
    input  wire logic                                 busGrant,
    output logic                                      latchReadStrobe,
    output logic                                      latchWriteStrobe,
    output logic [1:0]                                cpuIrqControlReg,
    output logic                                      controlEventIrq,
    output logic                                      dataXferIrq,
    output logic [parport_pkg::DMA_CHANNELS-1:0]      dmaRequest,
    output logic [parport_pkg::FLAG_WIDTH-1:0]        portIrqFlagReg,
    output logic [parport_pkg::FLAG_WIDTH-1:0]        portConditionReg,
    output logic [parport_pkg::FLAG_WIDTH-1:0]        portIrqMaskReg,
    output logic                                      dataRequestFlag,
    output logic                                      commandStatusFlag,
    output logic                                      hostReinitFlag,
    output logic [parport_pkg::TALLY_WIDTH-1:0]       capturedByteTally,
    output logic                                      byteAck,
    output logic                                      handshakeGo
);
    import parport_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [LINE_COUNT-1:0]  lastLine;
        logic [7:0]             edgeCond;
        logic                   reinitCond;
        logic                   cmdCond;
        logic [FLAG_WIDTH-1:0]  flags;
        logic [FLAG_WIDTH-1:0]  mask;
        logic                   dataReq;
        logic [TALLY_WIDTH-1:0] tally;
        logic                   byteAck;
        logic                   go;
        logic                   rdStrobe;
        logic                   wrStrobe;
        port_mode_type          lastMode;
    } state_type;

    state_type s;
    state_type next_s;

    logic [LINE_COUNT-1:0]  rise;
    logic [LINE_COUNT-1:0]  fall;
    logic [FLAG_WIDTH-1:0]  clr;
    logic [FLAG_WIDTH-1:0]  condNow;
    logic [FLAG_WIDTH-1:0]  condNext;
    logic                   byteIn;
    logic                   cmdHit;
    logic                   wordMode;
    logic                   accessDone;
    logic                   qPush;
    logic                   qPop;
    logic [QUEUE_WIDTH-1:0] qIn;
    logic [QUEUE_WIDTH-1:0] qOut;

    function automatic logic fullWordMode(input port_mode_type m, input logic en);
        fullWordMode = en && (m == MODE_COMPAT || m == MODE_ECP_FWD);
    endfunction : fullWordMode

    function automatic logic [FLAG_WIDTH-1:0] packCond(input logic [7:0] e,
                                                        input logic r, input logic c);
        packCond              = '0;
        packCond[7:0]         = e;
        packCond[BIT_REINIT]  = r;
        packCond[BIT_COMMAND] = c;
    endfunction : packCond

    // ------------------------------------------------------------
    // Access queue toward the bus arbiter
    // ------------------------------------------------------------
    // A DMA acknowledge takes the slot before a processor access
    // so the DMA channel is stalled only while the queue is full.
    assign qPush = dmaAck || cpuRead || cpuWrite;
    assign qIn   = dmaAck ? {(portMode == MODE_NIBBLE || portMode == MODE_BYTE ||
                              portMode == MODE_ECP_REV), 1'b1}
                          : {cpuWrite, 1'b0};

    access_queue #(
        .WIDTH (QUEUE_WIDTH),
        .DEPTH (QUEUE_DEPTH)
    ) accessFifo (
        .clk      (clk),
        .resetn   (resetn),
        .inValid  (qPush),
        .inReady  (dmaReady),
        .inData   (qIn),
        .outValid (accessReq),
        .outReady (busGrant),
        .outData  (qOut)
    );

    assign cpuReady    = dmaReady && !dmaAck;
    assign accessIsDma = qOut[0];
    assign qPop        = accessReq && busGrant;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_s     = s;
        rise       = hostLines & ~s.lastLine;
        fall       = ~hostLines & s.lastLine;
        clr        = statusClear ? clearBits : '0;
        // Compat entry clears reinit condition and flag like a write of 1
        if (portMode == MODE_COMPAT && s.lastMode != MODE_COMPAT) begin
            clr[BIT_REINIT] = 1'b1;
        end
        accessDone = s.rdStrobe || s.wrStrobe;
        wordMode   = fullWordMode(portMode, fullWordEnable);
        byteIn     = fall[LINE_STROBE] && (portMode == MODE_COMPAT || portMode == MODE_ECP_FWD);
        cmdHit     = byteIn && portMode == MODE_ECP_FWD &&
                     hostLines[LINE_AUTOFEED] == expectedCommandPolarity;

        next_s.lastLine = hostLines;
        next_s.lastMode = portMode;
        next_s.byteAck  = 1'b0;
        next_s.go       = 1'b0;
        next_s.rdStrobe = qPop && !qOut[1];
        next_s.wrStrobe = qPop && qOut[1];

        if (maskWrite) begin
            next_s.mask = maskValue & (FLAG_USED | (16'h0001 << BIT_DATA));
        end

        // Sticky conditions; the clear loses to a same-cycle set
        next_s.edgeCond   = s.edgeCond & ~clr[7:0];
        next_s.reinitCond = s.reinitCond && !clr[BIT_REINIT];
        next_s.cmdCond = s.cmdCond && !clr[BIT_COMMAND];
        if (s.cmdCond && clr[BIT_COMMAND]) begin
            next_s.go = 1'b1;
        end

        if (portMode != MODE_OFF) begin
            for (int i = 0; i < LINE_COUNT; i++) begin
                if (rise[i]) begin
                    next_s.edgeCond[2*i] = 1'b1;
                end
                if (fall[i]) begin
                    next_s.edgeCond[2*i+1] = 1'b1;
                end
            end
        end
        if (hostReinitReq) begin
            next_s.reinitCond = 1'b1;
        end

        // Data request: cleared by any window access, set wins
        if (accessDone || clr[BIT_DATA]) begin
            next_s.dataReq = 1'b0;
        end
        // Reading a held command byte does not release the host
        if (accessDone && !s.cmdCond && portMode != MODE_NIBBLE) begin
            next_s.go = 1'b1;
        end

        if (cmdHit) begin
            next_s.cmdCond = 1'b1;
        end else if (byteIn && wordMode) begin
            if (s.tally == TALLY_LAST) begin
                next_s.dataReq = 1'b1;
                next_s.tally   = TALLY_RESET;
            end else begin
                next_s.tally   = s.tally + 1'b1;
                next_s.byteAck = 1'b1;
            end
        end else if (byteIn) begin
            next_s.dataReq = 1'b1;
        end else if (reverseReady && portMode != MODE_OFF) begin
            next_s.dataReq = 1'b1;
        end

        if (!fullWordEnable) begin
            next_s.tally = TALLY_RESET;
        end

        // Flags latch masked conditions and stay until cleared
        condNext     = packCond(next_s.edgeCond, next_s.reinitCond, next_s.cmdCond);
        next_s.flags = (s.flags & ~clr & FLAG_USED) | (condNext & s.mask & FLAG_USED);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s          <= '0;
            s.mask     <= MASK_RESET;
            s.flags    <= FLAG_RESET;
            s.tally    <= TALLY_RESET;
            s.lastMode <= MODE_OFF;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign condNow           = packCond(s.edgeCond, s.reinitCond, s.cmdCond);
    assign controlEventIrq   = |s.flags;
    assign dataXferIrq       = s.dataReq && !dmaSelectBit && s.mask[BIT_DATA];
    assign cpuIrqControlReg  = {dataXferIrq, controlEventIrq};
    assign latchReadStrobe   = s.rdStrobe;
    assign latchWriteStrobe  = s.wrStrobe;
    assign portIrqFlagReg    = s.flags;
    assign portConditionReg  = condNow | (FLAG_WIDTH'(s.dataReq) << BIT_DATA);
    assign portIrqMaskReg    = s.mask;
    assign dataRequestFlag   = s.dataReq;
    assign commandStatusFlag = s.cmdCond;
    assign hostReinitFlag    = s.reinitCond;
    assign capturedByteTally = s.tally;
    assign byteAck           = s.byteAck;
    assign handshakeGo       = s.go;

    // No DMA in nibble mode: the data irq there still follows only the select bit and mask
    always_comb begin
        dmaRequest = '0;
        if (s.dataReq && dmaSelectBit && portMode != MODE_NIBBLE) begin
            dmaRequest[dmaChannelSelect] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    flag_from_cond_a: assert property (@(posedge clk) disable iff (!resetn)
        (condNow & s.mask & FLAG_USED & ~clr) != '0 |=> (s.flags & $past(condNow & s.mask & FLAG_USED & ~clr))
            == $past(condNow & s.mask & FLAG_USED & ~clr)) else $error("masked condition did not set flag");

    control_irq_or_a: assert property (@(posedge clk) disable iff (!resetn)
        controlEventIrq == (s.flags != '0) && cpuIrqControlReg[0] == controlEventIrq)
        else $error("control irq differs from flag OR");

    data_irq_gate_a: assert property (@(posedge clk) disable iff (!resetn)
        dataXferIrq |-> s.dataReq && !dmaSelectBit && cpuIrqControlReg[1]) else $error("bad data irq");

    dma_no_irq_a: assert property (@(posedge clk) disable iff (!resetn)
        s.dataReq && dmaSelectBit && portMode != MODE_NIBBLE |-> !dataXferIrq && dmaRequest != '0)
        else $error("DMA request missing or data irq raised");

    nibble_no_dma_a: assert property (@(posedge clk) disable iff (!resetn)
        portMode == MODE_NIBBLE |-> dmaRequest == '0) else $error("DMA request in nibble mode");

    strobe_clears_req_a: assert property (@(posedge clk) disable iff (!resetn)
        (latchReadStrobe || latchWriteStrobe) && !byteIn && !reverseReady |=> !dataRequestFlag)
        else $error("data request survived window access");

    grant_strobe_a: assert property (@(posedge clk) disable iff (!resetn)
        qPop |=> latchReadStrobe != latchWriteStrobe ##1 !latchReadStrobe || $past(qPop))
        else $error("latch strobe not issued for grant");

    command_hold_a: assert property (@(posedge clk) disable iff (!resetn)
        cmdHit && !dataRequestFlag && !reverseReady |=> commandStatusFlag && !dataRequestFlag)
        else $error("command byte raised a data request");

    command_no_go_a: assert property (@(posedge clk) disable iff (!resetn)
        commandStatusFlag && !(statusClear && clearBits[BIT_COMMAND]) |=> !handshakeGo)
        else $error("handshake released while command held");

    tally_clear_a: assert property (@(posedge clk) disable iff (!resetn)
        !fullWordEnable |=> capturedByteTally == TALLY_RESET) else $error("tally not cleared");

    word_ack_a: assert property (@(posedge clk) disable iff (!resetn)
        byteIn && !cmdHit && wordMode && capturedByteTally != TALLY_LAST |=> byteAck)
        else $error("intervening byte not acknowledged");

    reinit_clear_a: assert property (@(posedge clk) disable iff (!resetn)
        portMode == MODE_COMPAT && s.lastMode != MODE_COMPAT && !hostReinitReq |=> !hostReinitFlag)
        else $error("reinit not cleared on compat entry");

    mask_hold_a: assert property (@(posedge clk) disable iff (!resetn)
        !maskWrite |=> $stable(portIrqMaskReg)) else $error("mask changed without write");

endmodule : parallel_port_request_logic

// File: testbench/host_model.sv
`timescale 1ns/10ps
module host_model (
    input  wire logic       clk,
    input  wire logic       stall,
    input  wire logic       accessReq,
    input  wire logic       latchReadStrobe,
    output logic            busGrant,
    output logic [3:0]      hostLines
);
    int   wordBytes = 0;
    logic prevStrobe = 1'b1;

    initial hostLines = 4'hF;

    // ------------------------------------------------------------
    // Bus arbiter and external word latch
    // ------------------------------------------------------------
    // Stall lets the bench hold accesses back to fill the queue
    assign busGrant = accessReq & ~stall;

    always @(posedge clk) begin
        prevStrobe <= hostLines[0];
        if (latchReadStrobe) begin
            wordBytes <= 0;
        end else if (prevStrobe && !hostLines[0]) begin
            wordBytes <= (wordBytes + 1) % 4;
        end
    end

    // Command bit is set up a cycle ahead of the strobe edge
    task send_byte(input logic cmdBit);
        @(posedge clk);
        hostLines[1] <= cmdBit;
        @(posedge clk);
        hostLines[0] <= 1'b0;
        repeat (4) @(posedge clk);
        hostLines[0] <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask : send_byte

    // One low pulse on a control line: a falling then a rising edge
    task toggle_line(input int idx);
        @(posedge clk);
        hostLines[idx] <= 1'b0;
        repeat (2) @(posedge clk);
        hostLines[idx] <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask : toggle_line
endmodule : host_model

// File: testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
    import parport_pkg::*;
    logic          clk, resetn, hostReinitReq, reverseReady, maskWrite, statusClear, stall;
    logic          dmaSelectBit, dmaChannelSelect, fullWordEnable, expectedCommandPolarity;
    logic          cpuRead, cpuWrite, dmaAck;
    logic [15:0]   maskValue, clearBits;
    port_mode_type portMode;
    logic          cpuReady, dmaReady, accessReq, accessIsDma, busGrant, latchReadStrobe;
    logic          latchWriteStrobe, controlEventIrq, dataXferIrq, dataRequestFlag;
    logic          commandStatusFlag, hostReinitFlag, byteAck, handshakeGo;
    logic [1:0]    cpuIrqControlReg, dmaRequest, capturedByteTally;
    logic [15:0]   portIrqFlagReg, portConditionReg, portIrqMaskReg;
    logic [3:0]    hostLines;
    int            nFail = 0, nChecks = 0, nRd = 0, nWr = 0, nAck = 0, nGo = 0, mark;

    parallel_port_request_logic uut (.clk, .resetn, .portMode, .hostLines, .hostReinitReq,
        .reverseReady, .maskWrite, .maskValue, .statusClear, .clearBits, .dmaSelectBit,
        .dmaChannelSelect, .fullWordEnable, .expectedCommandPolarity, .cpuRead, .cpuWrite,
        .cpuReady, .dmaAck, .dmaReady, .accessReq, .accessIsDma, .busGrant, .latchReadStrobe,
        .latchWriteStrobe, .cpuIrqControlReg, .controlEventIrq, .dataXferIrq, .dmaRequest,
        .portIrqFlagReg, .portConditionReg, .portIrqMaskReg, .dataRequestFlag,
        .commandStatusFlag, .hostReinitFlag, .capturedByteTally, .byteAck, .handshakeGo);
    host_model host (.clk, .stall, .accessReq, .latchReadStrobe, .busGrant, .hostLines);

    // ------------------------------------------------------------
    // Clock, pulse counters and helpers
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        nRd  <= nRd + int'(latchReadStrobe);
        nWr  <= nWr + int'(latchWriteStrobe);
        nAck <= nAck + int'(byteAck);
        nGo  <= nGo + int'(handshakeGo);
    end

    task tally_and_finish;
        $display("checks %0d mismatches %0d", nChecks, nFail);
        if (nFail == 0 && nChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task check(input logic [15:0] seen, input logic [15:0] exp);
        nChecks++;
        if (seen !== exp) begin
            nFail++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task setm(input logic [15:0] v);
        @(posedge clk);
        maskWrite <= 1'b1;
        maskValue <= v;
        @(posedge clk);
        maskWrite <= 1'b0;
        @(negedge clk);
    endtask : setm

    task clr(input logic [15:0] v);
        @(posedge clk);
        statusClear <= 1'b1;
        clearBits   <= v;
        @(posedge clk);
        statusClear <= 1'b0;
        repeat (3) @(negedge clk);
    endtask : clr

    // Request is held until the edge that finds the queue ready
    task acc(input logic rd);
        int i;
        i = 0;
        @(posedge clk);
        cpuRead  <= rd;
        cpuWrite <= ~rd;
        @(negedge clk);
        while (cpuReady !== 1'b1 && i < 50) begin
            @(negedge clk);
            i++;
        end
        @(posedge clk);
        cpuRead  <= 1'b0;
        cpuWrite <= 1'b0;
        if (i >= 50) begin
            nFail++;
            tally_and_finish();
        end
        repeat (4) @(negedge clk);
    endtask : acc

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task sc_compat;
        check(portIrqMaskReg, 16'h0000);
        check(16'(cpuIrqControlReg), 16'h0);
        @(posedge clk);
        portMode <= MODE_COMPAT;
        setm(16'h8002);
        check(portIrqMaskReg, 16'h8002);
        host.send_byte(1'b0);
        check(portIrqFlagReg, 16'h0002);
        check(16'(controlEventIrq), 16'h1);
        check(16'(cpuIrqControlReg), 16'h3);
        acc(1'b1);
        acc(1'b0);
        check(16'({nRd[3:0], nWr[3:0]}), 16'h11);
        check(16'(dataRequestFlag), 16'h0);
        check(portIrqFlagReg, 16'h0002);
        clr(16'h0002);
        check(16'({portIrqFlagReg[1], portConditionReg[1], controlEventIrq}), 16'h0);
    endtask : sc_compat

    task sc_dma;
        @(posedge clk);
        dmaSelectBit     <= 1'b1;
        dmaChannelSelect <= 1'b1;
        host.send_byte(1'b0);
        check(16'({dmaRequest, dataXferIrq}), 16'h4);
        @(posedge clk);
        dmaAck <= 1'b1;
        stall  <= 1'b1;
        @(posedge clk);
        dmaAck <= 1'b0;
        @(negedge clk);
        check(16'(accessIsDma), 16'h1);
        @(posedge clk);
        stall <= 1'b0;
        repeat (4) @(negedge clk);
        check(16'({dmaRequest, nRd[3:0]}), 16'h2);
        @(posedge clk);
        dmaChannelSelect <= 1'b0;
        reverseReady     <= 1'b1;
        @(posedge clk);
        reverseReady <= 1'b0;
        @(negedge clk);
        check(16'({dataRequestFlag, dmaRequest}), 16'h5);
        clr(16'h8000);
        @(posedge clk);
        portMode     <= MODE_NIBBLE;
        reverseReady <= 1'b1;
        @(posedge clk);
        reverseReady <= 1'b0;
        repeat (2) @(negedge clk);
        check(16'({dataRequestFlag, dmaRequest}), 16'h4);
        @(posedge clk);
        dmaSelectBit <= 1'b0;
        @(negedge clk);
        check(16'(dataXferIrq), 16'h1);
        clr(16'h8000);
        check(16'(dataRequestFlag), 16'h0);
    endtask : sc_dma

    task sc_word;
        @(posedge clk);
        portMode       <= MODE_COMPAT;
        fullWordEnable <= 1'b1;
        repeat (3) host.send_byte(1'b0);
        check(16'({dataRequestFlag, capturedByteTally, nAck[3:0]}), 16'h33);
        host.send_byte(1'b0);
        check(16'({dataRequestFlag, capturedByteTally}), 16'h4);
        acc(1'b1);
        repeat (2) host.send_byte(1'b0);
        check(16'(capturedByteTally), 16'h2);
        @(posedge clk);
        fullWordEnable <= 1'b0;
        repeat (2) @(negedge clk);
        check(16'(capturedByteTally), 16'h0);
    endtask : sc_word

    task sc_ecp;
        clr(16'h00FF);
        @(posedge clk);
        portMode                <= MODE_ECP_FWD;
        fullWordEnable          <= 1'b1;
        expectedCommandPolarity <= 1'b1;
        setm(16'h4000);
        host.send_byte(1'b0);
        host.send_byte(1'b1);
        check(16'({commandStatusFlag, dataRequestFlag}), 16'h2);
        check(16'({capturedByteTally, portIrqFlagReg[14]}), 16'h3);
        mark = nGo;
        acc(1'b1);
        check(16'(nGo - mark), 16'h0);
        clr(16'h4000);
        check(16'({nGo[7:0] - mark[7:0], 7'h0, commandStatusFlag}), 16'h0100);
        @(posedge clk);
        expectedCommandPolarity <= 1'b0;
        host.send_byte(1'b0);
        check(16'({commandStatusFlag, dataRequestFlag}), 16'h2);
        clr(16'h4000);
        @(posedge clk);
        hostReinitReq <= 1'b1;
        @(posedge clk);
        hostReinitReq <= 1'b0;
        repeat (2) @(negedge clk);
        check(16'(hostReinitFlag), 16'h1);
        @(posedge clk);
        portMode <= MODE_COMPAT;
        repeat (2) @(negedge clk);
        check(16'(hostReinitFlag), 16'h0);
        setm(16'h00F0);
        host.toggle_line(2);
        host.toggle_line(3);
        check(portIrqFlagReg, 16'h00F0);
    endtask : sc_ecp

    task sc_queue;
        @(posedge clk);
        stall <= 1'b1;
        repeat (8) acc(1'b1);
        check(16'({cpuReady, dmaReady}), 16'h0);
        mark = nRd;
        @(posedge clk);
        stall <= 1'b0;
        repeat (12) @(negedge clk);
        check(16'(nRd - mark), 16'h8);
    endtask : sc_queue

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        {resetn, hostReinitReq, reverseReady, maskWrite, statusClear, stall} = '0;
        {dmaSelectBit, dmaChannelSelect, fullWordEnable, expectedCommandPolarity} = '0;
        {cpuRead, cpuWrite, dmaAck, maskValue, clearBits} = '0;
        portMode = MODE_OFF;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        sc_compat();
        sc_dma();
        sc_word();
        sc_ecp();
        sc_queue();
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge clk);
        nFail++;
        tally_and_finish();
    end
endmodule : testbench
